// file: serial_dac_pkg.sv
// Package with widths, codes and timing counts for the serial converter link
package serial_dac_pkg;
    localparam int unsigned CODE_W = 12;
    localparam logic [11:0] CODE_FULL = 12'hfff;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam int unsigned SYS_CLK_MHZ = 50;
    // Half period of the link clock the host makes, in ns
    localparam int unsigned LINK_HALF_NS = 80;
    localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] LINK_HALF_CNT = 4'(LINK_HALF_CYC - 1);
    localparam logic [3:0] BIT_LAST = 4'(CODE_W - 1);
endpackage

// file: serial_dac_if.sv
// Interface carrying the three-wire link plus load and clear strobes
`timescale 1ns/100ps
interface serial_dac_if;
    logic serial_clk;
    logic serial_data_in;
    logic select_n;
    logic load_strobe_n;
    logic zero_clear_n;
    modport host (output serial_clk, output serial_data_in, output select_n,
        output load_strobe_n, output zero_clear_n);
    modport dev (input serial_clk, input serial_data_in, input select_n,
        input load_strobe_n, input zero_clear_n);
endinterface

// file: serial_dac_dev.sv
// Converter end: shift register and double-buffered converter register
`timescale 1ns/100ps
module serial_dac_dev
    import serial_dac_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 50 MHz
    input wire logic rst_b_i, // Async reset, active low
    serial_dac_if.dev link, // Pins from the host
    output logic [11:0] dac_code_o, // Converter register code
    output logic [11:0] shift_word_o // Shift register contents
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [4:0] meta_ff, sync_ff, prev_ff;
    logic [4:0] nxt_meta, nxt_sync, nxt_prev;
    logic [11:0] shift_ff, nxt_shift;
    logic [11:0] code_ff, nxt_code;
    logic clk_rise, sel_rise, clk_lo, sel_lo, ld_lo, clr_lo;

    // Two flops per pin; edges are found after the second
    always_comb begin
        nxt_meta = {link.serial_clk, link.serial_data_in, link.select_n,
            link.load_strobe_n, link.zero_clear_n};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= 5'h1f;
            sync_ff <= 5'h1f;
            prev_ff <= 5'h1f;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // Decoded levels and edges
    assign clk_lo = !sync_ff[4];
    assign sel_lo = !sync_ff[2];
    assign ld_lo = !sync_ff[1];
    assign clr_lo = !sync_ff[0];
    assign clk_rise = sync_ff[4] && !prev_ff[4];
    assign sel_rise = sync_ff[2] && !prev_ff[2];

    // ************************************************************
    // Shift and converter registers
    // ************************************************************
    // Clock and select are interchangeable shift triggers
    always_comb begin
        nxt_shift = shift_ff;
        if ((clk_rise && sel_lo) || (sel_rise && clk_lo)) begin
            nxt_shift = {shift_ff[10:0], sync_ff[3]};
        end
        nxt_code = code_ff;
        if (clr_lo) begin
            nxt_code = CODE_ZERO;
        end else if (ld_lo) begin
            // Covers the falling edge, transparency and clear release
            nxt_code = nxt_shift;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_ff <= CODE_ZERO;
            code_ff <= CODE_ZERO;
        end else begin
            shift_ff <= nxt_shift;
            code_ff <= nxt_code;
        end
    end

    // Straight binary, so the code goes out unchanged
    assign dac_code_o = code_ff;
    assign shift_word_o = shift_ff;
endmodule

// file: serial_dac_host.sv
// Host end: sends one 12-bit word and strobes it into the converter
`timescale 1ns/100ps
module serial_dac_host
    import serial_dac_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 50 MHz
    input wire logic rst_b_i, // Async reset, active low
    serial_dac_if.host link, // Pins to the converter
    input wire logic send_i, // Pulse: send word_i
    input wire logic [11:0] word_i, // Code to send
    input wire logic clear_i, // Pulse: clear converter
    output logic busy_o // Transfer in progress
);
    typedef enum logic [2:0] {
        IDLE = 3'b000, SEL = 3'b001, LOW = 3'b011, HIGH = 3'b010,
        DESEL = 3'b110, LOAD = 3'b111, CLR = 3'b100
    } st_t;
    st_t st_ff, nxt_st;
    logic [11:0] word_ff, nxt_word;
    logic [3:0] bit_ff, nxt_bit, div_ff, nxt_div;
    logic sck_ff, nxt_sck, sel_ff, nxt_sel, ld_ff, nxt_ld, clr_ff, nxt_clr, busy_ff, nxt_busy;
    logic tick;

    // ************************************************************
    // Link sequencer
    // ************************************************************
    assign tick = (div_ff == LINK_HALF_CNT);

    // One state step per half link period
    always_comb begin
        nxt_st = st_ff; nxt_word = word_ff; nxt_bit = bit_ff;
        nxt_sck = sck_ff; nxt_sel = sel_ff; nxt_ld = ld_ff; nxt_clr = clr_ff;
        nxt_div = tick ? 4'h0 : div_ff + 4'h1;
        nxt_busy = busy_ff;
        case (st_ff)
            IDLE: begin
                nxt_div = 4'h0;
                if (clear_i) begin
                    nxt_clr = 1'b0;
                    nxt_st = CLR; nxt_busy = 1'b1;
                end else if (send_i) begin
                    nxt_word = word_i; nxt_bit = 4'h0;
                    nxt_st = SEL; nxt_busy = 1'b1;
                end
            end
            CLR: if (tick) begin
                nxt_clr = 1'b1; nxt_st = IDLE; nxt_busy = 1'b0;
            end
            SEL: if (tick) begin
                nxt_sel = 1'b0; nxt_st = LOW;
            end
            LOW: if (tick) begin
                nxt_sck = 1'b1; nxt_st = HIGH;
            end
            HIGH: if (tick) begin
                if (bit_ff == BIT_LAST) begin
                    // Select rises while the clock is still high: a rise with the
                    // clock low would shift one extra bit and push out the MSB
                    nxt_sel = 1'b1;
                    nxt_st = DESEL;
                end else begin
                    nxt_sck = 1'b0;
                    nxt_word = {word_ff[10:0], 1'b0};
                    nxt_bit = bit_ff + 4'h1;
                    nxt_st = LOW;
                end
            end
            DESEL: if (tick) begin
                // Clock falls with select already high, so nothing shifts
                nxt_sck = 1'b0;
                nxt_ld = 1'b0; nxt_st = LOAD;
            end
            LOAD: if (tick) begin
                // Load returns high before any further word
                nxt_ld = 1'b1; nxt_st = IDLE; nxt_busy = 1'b0;
            end
            default: nxt_st = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= IDLE; word_ff <= CODE_ZERO; bit_ff <= 4'h0; div_ff <= 4'h0;
            sck_ff <= 1'b0; sel_ff <= 1'b1; ld_ff <= 1'b1; clr_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st; word_ff <= nxt_word; bit_ff <= nxt_bit; div_ff <= nxt_div;
            sck_ff <= nxt_sck; sel_ff <= nxt_sel; ld_ff <= nxt_ld; clr_ff <= nxt_clr;
            busy_ff <= nxt_busy;
        end
    end

    // Data leads the clock rise by a half period, the first bit by a full period
    assign link.serial_clk = sck_ff;
    assign link.serial_data_in = word_ff[11];
    assign link.select_n = sel_ff;
    assign link.load_strobe_n = ld_ff;
    assign link.zero_clear_n = clr_ff;
    assign busy_o = busy_ff;
endmodule

// file: serial_dac_chk.sv
// Checker on the link pins and the converter end outputs
`timescale 1ns/100ps
module serial_dac_chk (
    input wire logic sys_clk_i, // Clock
    input wire logic rst_b_i, // Reset, low
    input wire logic serial_clk, // Link clock
    input wire logic serial_data_in, // Link data
    input wire logic select_n, // Select
    input wire logic load_strobe_n, // Load
    input wire logic zero_clear_n, // Clear
    input wire logic [11:0] dac_code_o, // Converter code
    input wire logic [11:0] shift_word_o // Shift word
);
    // ****************
    // Relations
    // ****************
    // Pins cross two sync flops, so dev reactions get a few cycles of slack
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    chk_load_deselected: assert property (!load_strobe_n |-> select_n)
        else $error("load low while selected");
    chk_select_load_high: assert property ($fell(select_n) |-> load_strobe_n)
        else $error("frame opened with load low");
    chk_data_on_fall: assert property ($changed(serial_data_in) |-> !serial_clk)
        else $error("data moved while clock high");
    chk_rise_shifts: assert property ($rose(serial_clk) && !select_n
        |-> ##[2:4] shift_word_o[0] == serial_data_in)
        else $error("bit not shifted in");
    chk_idle_no_shift: assert property (select_n [*6] |-> $stable(shift_word_o))
        else $error("shift while deselected");
    chk_code_held: assert property ((load_strobe_n && zero_clear_n) [*6]
        |-> $stable(dac_code_o))
        else $error("code moved without load");
    chk_load_copy: assert property ($fell(load_strobe_n) && zero_clear_n
        |-> ##[1:6] dac_code_o == shift_word_o)
        else $error("load did not copy");
    chk_clear_zero: assert property ($fell(zero_clear_n) |-> ##[1:5] dac_code_o == 12'h000)
        else $error("clear did not zero");
    chk_clear_holds: assert property (!zero_clear_n ##1 load_strobe_n [*8]
        |-> dac_code_o == 12'h000)
        else $error("zero not held");
endmodule

// file: tb_serial_dac_input_latch.sv
// Bench joining host and converter ends over the link
`timescale 1ns/100ps
module tb_serial_dac_input_latch;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic send_i = 1'b0;
    logic clear_i = 1'b0;
    logic [11:0] word_i = 12'h000;
    logic [11:0] last = 12'h000;
    logic busy_o;
    logic [11:0] dac_code_o;
    logic [11:0] shift_word_o;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    serial_dac_if link ();
    serial_dac_host u_serial_dac_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link.host), .send_i(send_i), .word_i(word_i), .clear_i(clear_i), .busy_o(busy_o));
    serial_dac_dev u_serial_dac_dev (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link.dev), .dac_code_o(dac_code_o), .shift_word_o(shift_word_o));
    serial_dac_chk u_serial_dac_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .serial_clk(link.serial_clk), .serial_data_in(link.serial_data_in),
        .select_n(link.select_n), .load_strobe_n(link.load_strobe_n),
        .zero_clear_n(link.zero_clear_n), .dac_code_o(dac_code_o), .shift_word_o(shift_word_o));
    // ****************
    // Clock, timeout, helpers
    // ****************
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // A full run needs about 1000 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    // Bounded wait for busy low, then slack for the dev sync flops
    task automatic wait_idle();
        #1;
        for (int i = 0; i < 300 && busy_o !== 1'b0; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask
    // Second request mid-word must be ignored by the busy host
    task automatic send(input logic [11:0] w);
        @(posedge sys_clk_i);
        send_i <= 1'b1;
        word_i <= w;
        @(posedge sys_clk_i);
        send_i <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        send_i <= 1'b1;
        word_i <= ~w;
        @(posedge sys_clk_i);
        send_i <= 1'b0;
        #1;
        chk("code mid word", last, dac_code_o);
        wait_idle();
        chk("shift word", w, shift_word_o);
        chk("code loaded", w, dac_code_o);
        last = w;
    endtask
    task automatic clear();
        @(posedge sys_clk_i);
        clear_i <= 1'b1;
        @(posedge sys_clk_i);
        clear_i <= 1'b0;
        wait_idle();
        chk("code cleared", 12'h000, dac_code_o);
        last = 12'h000;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic test_codes();
        logic [11:0] codes [6] = '{12'hfff, 12'h800, 12'h7ff, 12'h801, 12'h000, 12'ha5c};
        foreach (codes[k]) send(codes[k]);
        $display("test_codes done");
    endtask
    task automatic test_clear();
        send(12'h3c5);
        clear();
        chk("shift kept", 12'h3c5, shift_word_o);
        repeat (40) @(posedge sys_clk_i);
        #1;
        chk("zero held", 12'h000, dac_code_o);
        send(12'h5a3);
        $display("test_clear done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        clear();
        test_codes();
        test_clear();
        summarize();
    end
endmodule
